/* File: hdl/epr_pin_flags.sv */
// Purpose: port pin enables and request flags of external interrupt pins, apb slave
// Assumes: pins synchronous to pclk; manual_rst a synchronous active high pulse or level
// Notes:   pready always high, prdata captured in the setup cycle
//
// Our own choices: the APB register port and the placing of the registers.
`include "epr_defs.svh"
`timescale 1ns/1ps
`default_nettype none
module epr_pin_flags (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        manual_rst,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic [15:0] port_interrupt_pins,
  input  wire logic [5:0]  ext_request_pins,
  output logic             port_group_low_flag,
  output logic             port_group_high_flag,
  output logic [5:0]       ext_request_pin_flags,
  output logic             irq
);

  // bus request and decode
  epr_pkg::epr_apb_req_t req;
  logic                  setup_phase;
  logic                  access;
  logic                  wr_en;
  logic                  rd_en;
  logic                  hit_enable;
  logic                  hit_flags;
  logic                  hit_psense;
  logic                  hit_xsense;
  logic                  hit_istat;
  logic                  hit_imask;
  logic                  mapped;
  logic                  wr_enable_sel;
  logic                  wr_psense_sel;
  logic                  wr_xsense_sel;
  logic                  wr_flags_sel;
  logic                  wr_imask_sel;
  logic                  rd_flags_sel;
  logic                  rd_istat_sel;
  logic                  rd_capture;

  // registers
  logic [15:0]           port_pin_int_enable_ff;
  logic [15:0]           port_pin_sense_ff;
  logic [11:0]           ext_sense_ff;
  logic [7:0]            istat_ff;
  logic [7:0]            nxt_istat;
  logic [7:0]            imask_ff;
  logic [5:0]            armed_ff;
  logic [5:0]            nxt_armed;
  logic [31:0]           prdata_ff;
  logic [31:0]           nxt_prdata;
  logic                  irq_ff;

  // request state
  logic [15:0]           port_req;
  logic                  grp_low_ff;
  logic                  grp_high_ff;
  logic [5:0]            ext_flag;
  logic [5:0]            ext_clr;
  epr_pkg::epr_flags_t   flags;
  epr_pkg::epr_flags_t   flags_prev_ff;
  logic [7:0]            flag_rise;

  assign req.addr    = paddr;
  assign req.write   = pwrite;
  assign req.wdata   = pwdata;
  assign setup_phase = psel & ~penable;
  assign access      = psel & penable;
  assign wr_en       = access & req.write;
  assign rd_en       = access & ~req.write;

  assign hit_enable = (req.addr == `EPR_OFF_ENABLE);
  assign hit_flags  = (req.addr == `EPR_OFF_FLAGS);
  assign hit_psense = (req.addr == `EPR_OFF_PSENSE);
  assign hit_xsense = (req.addr == `EPR_OFF_XSENSE);
  assign hit_istat  = (req.addr == `EPR_OFF_ISTAT);
  assign hit_imask  = (req.addr == `EPR_OFF_IMASK);
  assign mapped     = hit_enable | hit_flags | hit_psense | hit_xsense | hit_istat | hit_imask;

  // one strobe per register access
  assign wr_enable_sel = wr_en & hit_enable;
  assign wr_psense_sel = wr_en & hit_psense;
  assign wr_xsense_sel = wr_en & hit_xsense;
  assign wr_flags_sel  = wr_en & hit_flags;
  assign wr_imask_sel  = wr_en & hit_imask;
  assign rd_flags_sel  = rd_en & hit_flags;
  assign rd_istat_sel  = rd_en & hit_istat;
  assign rd_capture    = setup_phase & ~req.write;

  // zero wait states; unmapped address answers with an error
  assign pready  = 1'b1;
  assign pslverr = access & ~mapped;

  // standby has no port: every register simply keeps its contents
  // port pin enable register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      port_pin_int_enable_ff <= `EPR_RST_ENABLE;
    end else if (manual_rst) begin
      port_pin_int_enable_ff <= `EPR_RST_ENABLE;
    end else if (wr_enable_sel) begin
      port_pin_int_enable_ff <= req.wdata[15:0];
    end
  end

  // sense registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      port_pin_sense_ff <= `EPR_RST_PSENSE;
      ext_sense_ff      <= `EPR_RST_XSENSE;
    end else if (manual_rst) begin
      port_pin_sense_ff <= `EPR_RST_PSENSE;
      ext_sense_ff      <= `EPR_RST_XSENSE;
    end else begin
      if (wr_psense_sel) begin
        port_pin_sense_ff <= req.wdata[15:0];
      end
      if (wr_xsense_sel) begin
        ext_sense_ff <= req.wdata[11:0];
      end
    end
  end

  // port pin requests: active level chosen per pin, gated by enable
  always_comb begin
    for (int i = 0; i < `EPR_NUM_PORT; i++) begin
      port_req[i] = port_pin_int_enable_ff[i] & ~(port_interrupt_pins[i] ^ port_pin_sense_ff[i]);
    end
  end

  // registered group flags give clean level outputs
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      grp_low_ff  <= 1'b0;
      grp_high_ff <= 1'b0;
    end else if (manual_rst) begin
      grp_low_ff  <= 1'b0;
      grp_high_ff <= 1'b0;
    end else begin
      grp_low_ff  <= |port_req[7:0];
      grp_high_ff <= |port_req[15:8];
    end
  end

  // clear only bits that were read as one, written as zero
  // arming stops a blind write from clearing a flag software never saw
  assign ext_clr = wr_flags_sel ? (armed_ff & ~req.wdata[5:0]) : 6'h00;

  // external request pin detectors
  for (genvar g = 0; g < `EPR_NUM_EXT; g++) begin : g_ext
    epr_ext_det u_det (
      .pclk       (pclk),
      .presetn    (presetn),
      .manual_rst (manual_rst),
      .pin        (ext_request_pins[g]),
      .sense      (epr_pkg::epr_sense_t'(ext_sense_ff[2*g +: 2])),
      .clr        (ext_clr[g]),
      .flag       (ext_flag[g])
    );
  end

  assign flags.grp_low  = grp_low_ff;
  assign flags.grp_high = grp_high_ff;
  assign flags.ext      = ext_flag;

  // arming for the read-then-write clear
  always_comb begin
    nxt_armed = armed_ff;
    if (rd_flags_sel) begin
      nxt_armed = prdata_ff[5:0];
    end else if (wr_flags_sel) begin
      nxt_armed = 6'h00;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      armed_ff <= 6'h00;
    end else if (manual_rst) begin
      armed_ff <= 6'h00;
    end else begin
      armed_ff <= nxt_armed;
    end
  end

  // interrupt status: rising edges of each flag, cleared by reading
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      flags_prev_ff <= `EPR_RST_FLAGS;
    end else if (manual_rst) begin
      flags_prev_ff <= `EPR_RST_FLAGS;
    end else begin
      flags_prev_ff <= flags;
    end
  end

  assign flag_rise = flags & ~flags_prev_ff;

  // a rise in the read cycle wins over the clear, so no event is lost
  always_comb begin
    nxt_istat = istat_ff;
    if (rd_istat_sel) begin
      nxt_istat = nxt_istat & ~prdata_ff[7:0];
    end
    nxt_istat = nxt_istat | flag_rise;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      istat_ff <= `EPR_RST_ISTAT;
    end else if (manual_rst) begin
      istat_ff <= `EPR_RST_ISTAT;
    end else begin
      istat_ff <= nxt_istat;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      imask_ff <= `EPR_RST_IMASK;
    end else if (manual_rst) begin
      imask_ff <= `EPR_RST_IMASK;
    end else if (wr_imask_sel) begin
      imask_ff <= req.wdata[7:0];
    end
  end

  // next status is used so a read clear drops irq one edge sooner
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_ff <= 1'b0;
    end else begin
      irq_ff <= |(nxt_istat & imask_ff);
    end
  end

  // read data captured in the setup cycle
  always_comb begin
    nxt_prdata = 32'h0000_0000;
    case (req.addr)
      `EPR_OFF_ENABLE: nxt_prdata[15:0] = port_pin_int_enable_ff;
      `EPR_OFF_FLAGS:  nxt_prdata[7:0]  = flags;
      `EPR_OFF_PSENSE: nxt_prdata[15:0] = port_pin_sense_ff;
      `EPR_OFF_XSENSE: nxt_prdata[11:0] = ext_sense_ff;
      `EPR_OFF_ISTAT:  nxt_prdata[7:0]  = istat_ff;
      `EPR_OFF_IMASK:  nxt_prdata[7:0]  = imask_ff;
      default:         nxt_prdata       = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_ff <= 32'h0000_0000;
    end else if (rd_capture) begin
      prdata_ff <= nxt_prdata;
    end
  end

  assign prdata                = prdata_ff;
  assign port_group_low_flag   = grp_low_ff;
  assign port_group_high_flag  = grp_high_ff;
  assign ext_request_pin_flags = ext_flag;
  assign irq                   = irq_ff;

endmodule
`default_nettype wire

/* File: shared/epr_defs.svh */
// Purpose: offsets, field positions and reset values of the pin request flag block
// Assumes: 32-bit apb data, one aligned word per register
// Notes:   included by bare name
`ifndef EPR_DEFS_SVH
`define EPR_DEFS_SVH

`define EPR_ADDR_W        12
`define EPR_OFF_ENABLE    12'h000
`define EPR_OFF_FLAGS     12'h004
`define EPR_OFF_PSENSE    12'h008
`define EPR_OFF_XSENSE    12'h00c
`define EPR_OFF_ISTAT     12'h010
`define EPR_OFF_IMASK     12'h014

`define EPR_NUM_PORT      16
`define EPR_NUM_EXT       6
`define EPR_GRP_LOW_BIT   7
`define EPR_GRP_HIGH_BIT  6

`define EPR_RST_ENABLE    16'h0000
`define EPR_RST_FLAGS     8'h00
`define EPR_RST_PSENSE    16'h0000
`define EPR_RST_XSENSE    12'h000
`define EPR_RST_ISTAT     8'h00
`define EPR_RST_IMASK     8'h00

`endif

/* File: shared/epr_pkg.sv */
// Purpose: types shared by the pin request flag block
// Assumes: nothing
// Notes:   constants live in epr_defs.svh
`default_nettype none
package epr_pkg;

  // detection mode of one external request pin
  typedef enum logic [1:0] {
    EPR_SENSE_FALL = 2'h0,
    EPR_SENSE_RISE = 2'h1,
    EPR_SENSE_LOW  = 2'h2,
    EPR_SENSE_RSVD = 2'h3
  } epr_sense_t;

  // layout of the request flag register, also of status and mask
  typedef struct packed {
    logic       grp_low;
    logic       grp_high;
    logic [5:0] ext;
  } epr_flags_t;

  typedef struct packed {
    logic [11:0] addr;
    logic        write;
    logic [31:0] wdata;
  } epr_apb_req_t;

endpackage
`default_nettype wire

/* File: hdl/epr_ext_det.sv */
// Purpose: request flag of one external request pin
// Assumes: pin synchronous to pclk
// Notes:   edge modes latch, low level mode follows the pin
`timescale 1ns/1ps
`default_nettype none
module epr_ext_det (
  input  wire logic              pclk,
  input  wire logic              presetn,
  input  wire logic              manual_rst,
  input  wire logic              pin,
  input  wire epr_pkg::epr_sense_t sense,
  input  wire logic              clr,
  output logic                   flag
);

  logic prev_ff;
  logic valid_ff;
  logic flag_ff;
  logic nxt_flag;
  logic hit;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prev_ff  <= 1'b1;
      valid_ff <= 1'b0;
    end else begin
      prev_ff  <= pin;
      valid_ff <= ~manual_rst;
    end
  end

  always_comb begin
    hit = 1'b0;
    case (sense)
      epr_pkg::EPR_SENSE_FALL: hit = valid_ff & prev_ff & ~pin;
      epr_pkg::EPR_SENSE_RISE: hit = valid_ff & ~prev_ff & pin;
      default:                 hit = 1'b0;
    endcase
  end

  always_comb begin
    nxt_flag = flag_ff;
    if (sense == epr_pkg::EPR_SENSE_LOW) begin
      nxt_flag = ~pin;
    end else if (hit) begin
      nxt_flag = 1'b1;
    end else if (clr) begin
      nxt_flag = 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      flag_ff <= 1'b0;
    end else if (manual_rst) begin
      flag_ff <= 1'b0;
    end else begin
      flag_ff <= nxt_flag;
    end
  end

  assign flag = flag_ff;

endmodule
`default_nettype wire

/* File: testbench/epr_checker.sv */
// Purpose: port checks of the pin request flag block
// Assumes: pins synchronous to pclk
// Notes:   shadows enable and port sense writes
`include "epr_defs.svh"
`timescale 1ns/1ps
`default_nettype none
module epr_checker (
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        manual_rst,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic [15:0] port_interrupt_pins,
  input wire logic [5:0]  ext_request_pins,
  input wire logic        port_group_low_flag,
  input wire logic        port_group_high_flag,
  input wire logic [5:0]  ext_request_pin_flags,
  input wire logic        irq
);
  logic [15:0] en_ff;
  logic [15:0] sns_ff;
  logic        acc;
  logic        mapped;
  logic        wr_x;
  logic [15:0] act;
  assign acc    = psel && penable;
  assign mapped = paddr inside {`EPR_OFF_ENABLE, `EPR_OFF_FLAGS, `EPR_OFF_PSENSE,
                                `EPR_OFF_XSENSE, `EPR_OFF_ISTAT, `EPR_OFF_IMASK};
  assign wr_x   = acc && pwrite && paddr == `EPR_OFF_XSENSE;
  assign act    = en_ff & ~(port_interrupt_pins ^ sns_ff);
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      en_ff  <= 16'h0000;
      sns_ff <= 16'h0000;
    end else if (manual_rst) begin
      en_ff  <= 16'h0000;
      sns_ff <= 16'h0000;
    end else if (acc && pwrite) begin
      if (paddr == `EPR_OFF_ENABLE) en_ff <= pwdata[15:0];
      if (paddr == `EPR_OFF_PSENSE) sns_ff <= pwdata[15:0];
    end
  end
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence s_rd(logic [11:0] off);
    acc && !pwrite && paddr == off;
  endsequence
  a_group_low: assert property (!$past(manual_rst) |-> port_group_low_flag == $past(|act[7:0]))
    else $error("low group flag wrong");
  a_group_high: assert property (!$past(manual_rst) |-> port_group_high_flag == $past(|act[15:8]))
    else $error("high group flag wrong");
  a_flags_read: assert property (s_rd(`EPR_OFF_FLAGS) |->
    prdata == {24'h0, $past({port_group_low_flag, port_group_high_flag, ext_request_pin_flags})})
    else $error("flag read wrong");
  a_enable_read: assert property (s_rd(`EPR_OFF_ENABLE) |-> prdata == {16'h0, $past(en_ff)})
    else $error("enable read wrong");
  a_ext_rise_cause: assert property ((|(ext_request_pin_flags & ~$past(ext_request_pin_flags)
    & ~($past(ext_request_pins) ^ $past(ext_request_pins, 2)))) |-> $past(wr_x) || $past(wr_x, 2))
    else $error("flag set without pin change");
  a_manual_clr: assert property (manual_rst |=> ext_request_pin_flags == 6'h00 ##1 !irq)
    else $error("manual reset left flags");
  a_unmapped_err: assert property (acc && !mapped |-> pslverr && (pwrite || prdata == 32'h0))
    else $error("unmapped access not refused");
  a_idle_quiet: assert property (!acc |-> pready && !pslverr)
    else $error("error outside access");
endmodule
bind epr_pin_flags epr_checker chk_u (.pclk(pclk), .presetn(presetn), .manual_rst(manual_rst),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .port_interrupt_pins(port_interrupt_pins),
  .ext_request_pins(ext_request_pins), .port_group_low_flag(port_group_low_flag),
  .port_group_high_flag(port_group_high_flag), .ext_request_pin_flags(ext_request_pin_flags), .irq(irq));
`default_nettype wire

/* File: testbench/epr_pin_model.sv */
// Purpose: external devices driving the request pins
// Assumes: levels change once per clock
// Notes:   pins follow bench levels one edge later
`timescale 1ns/1ps
`default_nettype none
module epr_pin_model (
  input  wire logic        pclk,
  input  wire logic [15:0] port_lv,
  input  wire logic [5:0]  ext_lv,
  output logic [15:0]      port_interrupt_pins,
  output logic [5:0]       ext_request_pins
);
  always_ff @(posedge pclk) begin
    port_interrupt_pins <= port_lv;
    ext_request_pins    <= ext_lv;
  end
endmodule
`default_nettype wire

/* File: testbench/tb.sv */
// Purpose: self-checking bench of the pin request flag block
// Assumes: pins come from epr_pin_model
// Notes:   group cases as table rows, then hand tests
`include "epr_defs.svh"
`timescale 1ns/1ps
`default_nettype none
module tb;
  typedef struct packed {
    logic [15:0] en;
    logic [15:0] sns;
    logic [15:0] pin;
    logic [1:0]  grp;
  } epr_row_t;
  logic        pclk;
  logic        presetn = 1'b0;
  logic        manual_rst = 1'b0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [15:0] port_lv = 16'h0000;
  logic [5:0]  ext_lv = 6'h3f;
  logic [3:0]  lo_exp = 4'h5;
  logic [3:0]  hi_exp = 4'h3;
  logic [31:0] prdata, rd;
  logic [15:0] pins;
  logic [5:0]  xpins, xf;
  logic        pready, pslverr, irq, glo, ghi, er;
  int          n_errors = 0;
  int          compares = 0;
  int          n;
  epr_row_t    rows [6];
  epr_pin_flags dut_u (.pclk(pclk), .presetn(presetn), .manual_rst(manual_rst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .port_interrupt_pins(pins), .ext_request_pins(xpins), .port_group_low_flag(glo),
    .port_group_high_flag(ghi), .ext_request_pin_flags(xf), .irq(irq));
  epr_pin_model pm_u (.pclk(pclk), .port_lv(port_lv), .ext_lv(ext_lv), .port_interrupt_pins(pins),
    .ext_request_pins(xpins));
  initial begin
    pclk = 1'b0;
    forever #20 pclk = ~pclk;
  end
  task automatic tick(input int k);
    repeat (k) @(posedge pclk);
  endtask
  task automatic report_and_stop;
    if (n_errors == 0 && compares > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    compares++;
    if (g !== e) begin
      n_errors++;
      $display("unexpected at %0t: got %h exp %h", $time, g, e);
    end
  endtask
  task automatic apb(input logic [11:0] a, input logic w, input logic [31:0] d);
    int k;
    psel    <= 1'b1;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge pclk);
      k++;
    end while (pready !== 1'b1 && k < 16);
    if (k >= 16) begin
      n_errors++;
      report_and_stop();
    end
    rd = prdata;
    er = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic clr(input logic [5:0] b);
    apb(`EPR_OFF_FLAGS, 1'b0, 32'h0);
    apb(`EPR_OFF_FLAGS, 1'b1, {26'h0, ~b});
  endtask
  initial begin
    rows = '{'{16'h0000, 16'h0000, 16'h0000, 2'b00}, '{16'h00ff, 16'h0000, 16'hffff, 2'b00},
             '{16'h0001, 16'h0000, 16'hfffe, 2'b10}, '{16'h8000, 16'h8000, 16'h8000, 2'b01},
             '{16'hff00, 16'h0000, 16'h00ff, 2'b01}, '{16'hffff, 16'hffff, 16'h0080, 2'b10}};
    tick(20);
    presetn <= 1'b1;
    tick(1);
    for (int i = 0; i < 6; i++) begin
      apb(12'(4 * i), 1'b0, 32'h0);
      chk(rd, 32'h0);
    end
    foreach (rows[i]) begin
      apb(`EPR_OFF_ENABLE, 1'b1, {16'h0, rows[i].en});
      apb(`EPR_OFF_PSENSE, 1'b1, {16'h0, rows[i].sns});
      port_lv <= rows[i].pin;
      tick(3);
      apb(`EPR_OFF_FLAGS, 1'b0, 32'h0);
      chk(rd, {24'h0, rows[i].grp, 6'h00});
      chk({glo, ghi}, rows[i].grp);
      apb(`EPR_OFF_ENABLE, 1'b0, 32'h0);
      chk(rd, {16'h0, rows[i].en});
    end
    for (int m = 0; m < 4; m++) begin
      apb(`EPR_OFF_XSENSE, 1'b1, 32'(m << 2));
      clr(6'h02);
      ext_lv <= 6'h3d;
      tick(3);
      chk(xf[1], lo_exp[m]);
      if (m == 2) begin
        clr(6'h02);
        chk(xf[1], 1'b1);
      end
      ext_lv <= 6'h3f;
      tick(3);
      chk(xf[1], hi_exp[m]);
    end
    ext_lv <= 6'h3e;
    tick(3);
    apb(`EPR_OFF_FLAGS, 1'b1, 32'h3f);
    apb(`EPR_OFF_FLAGS, 1'b1, 32'h0);
    chk(xf, 6'h01);
    clr(6'h01);
    chk(xf, 6'h00);
    apb(`EPR_OFF_ISTAT, 1'b0, 32'h0);
    apb(`EPR_OFF_IMASK, 1'b1, 32'h01);
    ext_lv <= 6'h3b;
    tick(4);
    chk(irq, 1'b0);
    apb(`EPR_OFF_ISTAT, 1'b0, 32'h0);
    chk(rd, 32'h04);
    ext_lv <= 6'h3a;
    n = 0;
    while (irq !== 1'b1 && n < 10) begin
      @(posedge pclk);
      n++;
    end
    chk(irq, 1'b1);
    if (n >= 10) report_and_stop();
    apb(`EPR_OFF_ISTAT, 1'b0, 32'h0);
    chk(rd, 32'h01);
    tick(2);
    chk(irq, 1'b0);
    apb(12'h018, 1'b1, 32'hffffffff);
    chk(er, 1'b1);
    apb(12'h018, 1'b0, 32'h0);
    chk(rd, 32'h0);
    for (int k = 0; k < 2; k++) begin
      apb(`EPR_OFF_ENABLE, 1'b1, 32'hffff);
      presetn    <= k[0];
      manual_rst <= k[0];
      tick(2);
      presetn    <= 1'b1;
      manual_rst <= 1'b0;
      tick(1);
      apb(`EPR_OFF_ENABLE, 1'b0, 32'h0);
      chk(rd, 32'h0);
      chk(xf, 6'h00);
    end
    report_and_stop();
  end
endmodule
`default_nettype wire
